//--- design/otpsp_device.sv
// otpsp_device: device end; parameter space, one-time-programmable space, status and config
// assumes mode 0 framing: data sampled on rising sck, changed after falling sck, msb first
//
// Summary of operation
// RULE_01 - command 5Ah reads separate parameter space
// RULE_02 - parameter space is never host-writable
// RULE_03 - identification data is one parameter table
// RULE_04 - otp space is 1024 bytes, 000-3FF
// RULE_05 - 32 regions of 32 bytes, each lockable
// RULE_06 - random number bytes 000-00F never programmable
// RULE_07 - bytes 010-013 hold one lock bit/region
// RULE_08 - lock bit zero blocks region programming
// RULE_09 - host locks region by programming its bit
// RULE_10 - reserved bytes 014-01F programmable, delivered FF
// RULE_11 - regions 1-31 delivered erased to FF
// RULE_12 - freeze bit set rejects all otp programming
// RULE_13 - boot code programs then sets freeze bit
// RULE_14 - registers reached only by their commands
// RULE_15 - volatile bits take defaults on reset
// RULE_16 - otp contents survive every reset
// RULE_17 - locked-region program sets program error flag
// RULE_18 - clear status command 30h clears error
// RULE_19 - refused programming leaves bytes unchanged
// RULE_20 - address bits 9:0 used, region bits 9:5
//
// Chosen here: register access over Avalon-MM and the address map.
module otpsp_device (
    input  wire logic     clk_sys_i,
    input  wire logic     rst_n_i,
    otpsp_link_if.dev     link,
    output logic [7:0]    status_reg_one_o,
    output logic [7:0]    config_reg_one_o
);
    typedef enum logic [2:0] {
        OTPSP_D_OP, OTPSP_D_A0, OTPSP_D_A1, OTPSP_D_DATA, OTPSP_D_OUT, OTPSP_D_DONE
    } otpsp_dev_st_t;

    // both arrays are plain storage with no reset: contents outlive every reset
    logic [7:0] otp_mem [0:otpsp_pkg::OTP_BYTES-1];   // RULE_16
    logic [7:0] param_mem [0:otpsp_pkg::PARAM_BYTES-1];

    // factory image: random number, lock and reserved bytes and regions erased
    initial begin
        for (int i = 0; i < otpsp_pkg::OTP_BYTES; i++) begin
            otp_mem[i] = otpsp_pkg::ERASED_BYTE;  // RULE_10 RULE_11
        end
        for (int i = 0; i <= 15; i++) begin
            otp_mem[i] = 8'(8'hA5 ^ (i * 37)); // RULE_06 arbitrary stand-in number
        end
        // signature header then identification table as first parameter table
        for (int i = 0; i < otpsp_pkg::PARAM_BYTES; i++) begin
            param_mem[i] = 8'(i);              // RULE_03 arbitrary table contents
        end
        param_mem[0] = 8'h53;
        param_mem[1] = 8'h46;
        param_mem[2] = 8'h44;
        param_mem[3] = 8'h50;
    end

    // every input pin passes two flops; the sequencer sees each edge about three clocks late
    logic cs_s, sck_s, mosi_s, sck_d_reg;
    otpsp_sync u_cs   (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .d_i(link.cs_n), .q_o(cs_s));
    otpsp_sync u_sck  (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .d_i(link.sck),  .q_o(sck_s));
    otpsp_sync u_mosi (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .d_i(link.mosi), .q_o(mosi_s));

    // edges count only while selected, so clock noise between frames is ignored
    wire sck_rise = sck_s & ~sck_d_reg & ~cs_s;
    wire sck_fall = ~sck_s & sck_d_reg & ~cs_s;

    otpsp_dev_st_t st_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  op_reg;
    logic [15:0] addr_reg;
    logic [7:0]  out_reg;
    logic [7:0]  stat_reg;
    logic [7:0]  cfg_reg;
    logic        miso_reg;

    wire [7:0] byte_in = {shift_reg[6:0], mosi_s};
    wire       byte_end = sck_rise && (bit_reg == 3'd7);

    // otp address decode uses only 10 bits; region from the top five
    // lock bit zero means locked; erased lock bytes leave every region open
    wire [9:0] otp_a    = addr_reg[otpsp_pkg::OTP_AW-1:0];       // RULE_20 RULE_04
    wire [4:0] region   = otp_a[9:otpsp_pkg::REGION_LSB];        // RULE_05 RULE_20
    wire [31:0] lock_w  = {otp_mem[otpsp_pkg::LOCK_LAST], otp_mem[10'h012],
                           otp_mem[10'h011], otp_mem[otpsp_pkg::LOCK_FIRST]}; // RULE_07
    wire region_locked  = ~lock_w[region];                       // RULE_08
    wire in_random      = (otp_a <= otpsp_pkg::RAND_LAST);       // RULE_06
    wire frozen         = cfg_reg[otpsp_pkg::CFG_FREEZE_BIT];    // RULE_12
    wire prog_ok        = ~frozen & ~region_locked & ~in_random;
    wire prog_bad       = frozen | region_locked;                // RULE_17

    // byte to send for the current read command
    wire [7:0] rd_byte =
        (op_reg == otpsp_pkg::CMD_READ_PARAM) ? param_mem[addr_reg[7:0]] :     // RULE_01
        (op_reg == otpsp_pkg::CMD_OTP_READ)   ? otp_mem[otp_a] :
        (op_reg == otpsp_pkg::CMD_READ_STAT1) ? stat_reg : cfg_reg;            // RULE_14

    wire is_addr_cmd = (byte_in == otpsp_pkg::CMD_READ_PARAM) ||
                       (byte_in == otpsp_pkg::CMD_OTP_READ) ||
                       (byte_in == otpsp_pkg::CMD_OTP_PROG);
    wire is_rd_reg   = (byte_in == otpsp_pkg::CMD_READ_STAT1) ||
                       (byte_in == otpsp_pkg::CMD_READ_CFG1);

    // programming only clears bits; refused writes touch nothing
    // a plain clocked always: the factory image in the initial block writes this array too
    always @(posedge clk_sys_i) begin
        if (st_reg == OTPSP_D_DATA && byte_end && op_reg == otpsp_pkg::CMD_OTP_PROG
            && prog_ok) begin
            otp_mem[otp_a] <= otp_mem[otp_a] & byte_in; // RULE_19 RULE_09
        end
    end

    // command sequencer; volatile registers take defaults on reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_reg    <= OTPSP_D_OP;
            sck_d_reg <= 1'b0;
            shift_reg <= 8'h00;
            bit_reg   <= 3'd0;
            op_reg    <= 8'h00;
            addr_reg  <= 16'h0000;
            out_reg   <= 8'h00;
            stat_reg  <= otpsp_pkg::STAT1_RST;   // RULE_15
            cfg_reg   <= otpsp_pkg::CFG1_RST;    // RULE_15
            miso_reg  <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
            // deselect drops a cut frame; a partly shifted program byte is never applied
            if (cs_s) begin
                st_reg  <= OTPSP_D_OP;
                bit_reg <= 3'd0;
            end else begin
                if (sck_rise) begin
                    shift_reg <= byte_in;
                    bit_reg   <= bit_reg + 3'd1;
                end
                // reply changes after a falling edge and stands through the next high phase
                if (sck_fall && st_reg == OTPSP_D_OUT) begin
                    miso_reg <= out_reg[7];
                    out_reg  <= {out_reg[6:0], 1'b0};
                end
                if (byte_end) begin
                    case (st_reg)
                        OTPSP_D_OP: begin
                            // unknown opcodes are ignored until the frame ends
                            op_reg <= byte_in;
                            if (byte_in == otpsp_pkg::CMD_CLEAR_STATUS) begin
                                stat_reg[otpsp_pkg::STAT_PERR_BIT] <= 1'b0; // RULE_18
                                st_reg <= OTPSP_D_DONE;
                            end else if (is_addr_cmd) begin
                                st_reg <= OTPSP_D_A0;
                            end else if (byte_in == otpsp_pkg::CMD_WRITE_REGS) begin
                                st_reg <= OTPSP_D_DATA;
                            end else if (is_rd_reg) begin
                                out_reg <= (byte_in == otpsp_pkg::CMD_READ_STAT1) ?
                                           stat_reg : cfg_reg;
                                st_reg  <= OTPSP_D_OUT;
                            end else begin
                                st_reg <= OTPSP_D_DONE;
                            end
                        end
                        OTPSP_D_A0: begin
                            // only bits 9:8 of the high byte reach the otp decode
                            addr_reg[15:8] <= byte_in;
                            st_reg <= OTPSP_D_A1;
                        end
                        OTPSP_D_A1: begin
                            addr_reg[7:0] <= byte_in;
                            if (op_reg == otpsp_pkg::CMD_OTP_PROG) begin
                                st_reg <= OTPSP_D_DATA;
                            end else begin
                                st_reg  <= OTPSP_D_OUT;
                                out_reg <= (op_reg == otpsp_pkg::CMD_READ_PARAM) ?
                                           param_mem[byte_in] :
                                           otp_mem[{addr_reg[9:8], byte_in}];
                            end
                        end
                        OTPSP_D_DATA: begin
                            if (op_reg == otpsp_pkg::CMD_WRITE_REGS) begin
                                // freeze cannot be cleared until the next reset
                                cfg_reg <= byte_in | (cfg_reg & 8'h01); // RULE_13
                                st_reg  <= OTPSP_D_DONE;
                            end else begin
                                // the address walks on, so one frame may program a run of bytes
                                if (prog_bad) begin
                                    stat_reg[otpsp_pkg::STAT_PERR_BIT] <= 1'b1; // RULE_17
                                end
                                addr_reg <= addr_reg + 16'd1;
                            end
                        end
                        OTPSP_D_OUT: begin
                            // the parameter space has no write path at all
                            addr_reg <= addr_reg + 16'd1;                  // RULE_02
                            out_reg  <= (op_reg == otpsp_pkg::CMD_READ_PARAM) ?
                                        param_mem[8'(addr_reg + 16'd1)] :
                                        (op_reg == otpsp_pkg::CMD_OTP_READ) ?
                                        otp_mem[10'(addr_reg + 16'd1)] : rd_byte;
                        end
                        default: st_reg <= OTPSP_D_DONE;
                    endcase
                end
            end
        end
    end

    // outputs come straight from flops
    assign link.miso        = miso_reg;
    assign status_reg_one_o = stat_reg;
    assign config_reg_one_o = cfg_reg;
endmodule

//--- design/otpsp_host.sv
// otpsp_host: host controller; takes orders over avalon-mm and runs serial commands
// assumes the device samples on rising sck; this end makes sck by a divider
module otpsp_host (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    otpsp_link_if.host       link
);
    logic miso_s;
    otpsp_sync u_miso (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .d_i(link.miso), .q_o(miso_s));

    logic [2:0]  cmd_reg;
    logic [15:0] addr_reg;
    logic [7:0]  wdata_reg, rdata_reg;
    logic        busy_reg, cs_n_reg, sck_reg, ack_reg;
    logic [39:0] tx_reg;
    logic [5:0]  nbits_reg;
    logic [3:0]  div_reg;

    // frame length and contents per command: opcode, address, data byte
    function automatic logic [7:0] host_op(input logic [2:0] c);
        case (c)
            otpsp_pkg::HC_PARAM_RD: host_op = otpsp_pkg::CMD_READ_PARAM;   // RULE_01
            otpsp_pkg::HC_OTP_RD:   host_op = otpsp_pkg::CMD_OTP_READ;
            otpsp_pkg::HC_OTP_PROG: host_op = otpsp_pkg::CMD_OTP_PROG;     // RULE_09
            otpsp_pkg::HC_CLEAR:    host_op = otpsp_pkg::CMD_CLEAR_STATUS; // RULE_18
            otpsp_pkg::HC_STAT_RD:  host_op = otpsp_pkg::CMD_READ_STAT1;   // RULE_14
            otpsp_pkg::HC_CFG_WR:   host_op = otpsp_pkg::CMD_WRITE_REGS;   // RULE_13
            default:                host_op = otpsp_pkg::CMD_READ_CFG1;
        endcase
    endfunction

    wire [2:0]  new_cmd = avs_writedata[2:0];
    wire        has_adr = (new_cmd == otpsp_pkg::HC_PARAM_RD) ||
                          (new_cmd == otpsp_pkg::HC_OTP_RD) ||
                          (new_cmd == otpsp_pkg::HC_OTP_PROG);
    wire        one_b   = (new_cmd == otpsp_pkg::HC_CLEAR);
    wire [5:0]  frame_n = one_b ? 6'd8 : has_adr ? 6'd32 : 6'd16;
    wire [39:0] frame   = {host_op(new_cmd), has_adr ? addr_reg : {wdata_reg, 8'h00},
                           has_adr ? wdata_reg : 8'h00, 8'h00};
    wire        start   = avs_write && avs_address == otpsp_pkg::CR_CMD && !busy_reg && !ack_reg;
    wire        tick    = busy_reg && div_reg == 4'(otpsp_pkg::SCK_HALF - 1);
    wire        acc     = (avs_read || avs_write) && !ack_reg;
    wire        ack_nx  = acc && !(avs_write && avs_address == otpsp_pkg::CR_CMD && busy_reg);
    wire        wr_adr  = acc && avs_write && avs_address == otpsp_pkg::CR_ADDR;
    wire        wr_dat  = acc && avs_write && avs_address == otpsp_pkg::CR_WDATA;
    wire [31:0] rd_mux  =
        (avs_address == otpsp_pkg::CR_CMD)    ? {29'h0, cmd_reg} :
        (avs_address == otpsp_pkg::CR_ADDR)   ? {16'h0, addr_reg} :
        (avs_address == otpsp_pkg::CR_WDATA)  ? {24'h0, wdata_reg} :
        (avs_address == otpsp_pkg::CR_RDATA)  ? {24'h0, rdata_reg} :
        (avs_address == otpsp_pkg::CR_STATUS) ? {31'h0, busy_reg} : 32'h0;

    // bus slave: one wait cycle, command writes stall while a frame runs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ack_reg      <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            cmd_reg      <= 3'h0;
            addr_reg     <= 16'h0;
            wdata_reg    <= 8'h0;
        end else begin
            ack_reg         <= ack_nx;
            avs_waitrequest <= !ack_nx;
            if (acc && avs_read) avs_readdata <= rd_mux;
            if (wr_adr) addr_reg <= avs_writedata[15:0];
            if (wr_dat) wdata_reg <= avs_writedata[7:0];
            if (start) cmd_reg <= new_cmd;
        end
    end

    // serial engine: mosi changes at falling sck, miso taken just before falling sck
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0; cs_n_reg <= 1'b1; sck_reg <= 1'b0;
            tx_reg <= 40'h0; nbits_reg <= 6'd0; div_reg <= 4'd0; rdata_reg <= 8'h0;
        end else if (start) begin
            busy_reg <= 1'b1; cs_n_reg <= 1'b0; tx_reg <= frame;
            nbits_reg <= frame_n; div_reg <= 4'd0;
        end else if (tick) begin
            div_reg <= 4'd0;
            if (!sck_reg && nbits_reg != 6'd0) begin
                sck_reg <= 1'b1;
            end else if (sck_reg) begin
                // reply bit taken at the end of the high phase: the device answers about
                // three clocks after each falling edge and the reply needs two more to sync
                rdata_reg <= {rdata_reg[6:0], miso_s};
                sck_reg <= 1'b0; tx_reg <= {tx_reg[38:0], 1'b0}; nbits_reg <= nbits_reg - 6'd1;
            end else begin
                busy_reg <= 1'b0; cs_n_reg <= 1'b1;
            end
        end else if (busy_reg) begin
            div_reg <= div_reg + 4'd1;
        end
    end
    assign link.cs_n = cs_n_reg;
    assign link.sck  = sck_reg;
    assign link.mosi = tx_reg[39];
endmodule

//--- design/otpsp_link_if.sv
// otpsp_link_if: serial link with separate command (mosi) and reply (miso) data lines between host controller and device
// assumes the bench supplies the wires; the host drives select, clock and command data
interface otpsp_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    modport host (output cs_n, output sck, output mosi, input miso);
    modport dev  (input cs_n, input sck, input mosi, output miso);
endinterface

//--- design/otpsp_pkg.sv
// otpsp_pkg: shared constants for the parameter-space / one-time-programmable block
// assumes both ends of the serial link include nothing else; all names are scoped
package otpsp_pkg;
    // serial command opcodes
    localparam logic [7:0] CMD_READ_PARAM   = 8'h5A;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] CMD_OTP_READ     = 8'h4B;
    localparam logic [7:0] CMD_OTP_PROG     = 8'h42;
    localparam logic [7:0] CMD_READ_STAT1   = 8'h05;
    localparam logic [7:0] CMD_READ_CFG1    = 8'h35;
    localparam logic [7:0] CMD_WRITE_REGS   = 8'h01;
    // one-time-programmable space layout
    localparam int         OTP_BYTES        = 1024;
    localparam int         OTP_AW           = 10;
    localparam int         REGION_LSB       = 5;
    localparam logic [9:0] RAND_LAST        = 10'h00F;
    localparam logic [9:0] LOCK_FIRST       = 10'h010;
    localparam logic [9:0] LOCK_LAST        = 10'h013;
    localparam logic [7:0] ERASED_BYTE      = 8'hFF;
    // parameter space size
    localparam int         PARAM_BYTES      = 256;
    localparam int         PARAM_AW         = 8;
    // register fields and volatile reset values
    localparam int         CFG_FREEZE_BIT   = 0;
    localparam int         STAT_PERR_BIT    = 6;
    localparam logic [7:0] STAT1_RST        = 8'h00;
    localparam logic [7:0] CFG1_RST         = 8'h00;
    // controller register offsets (avalon word addresses)
    localparam logic [2:0] CR_CMD           = 3'h0;
    localparam logic [2:0] CR_ADDR          = 3'h1;
    localparam logic [2:0] CR_WDATA         = 3'h2;
    localparam logic [2:0] CR_RDATA         = 3'h3;
    localparam logic [2:0] CR_STATUS        = 3'h4;
    // serial clock divider: half period in system clocks
    localparam int         SCK_HALF         = 4;
    // host command codes written to the command register
    localparam logic [2:0] HC_PARAM_RD      = 3'h1;
    localparam logic [2:0] HC_OTP_RD        = 3'h2;
    localparam logic [2:0] HC_OTP_PROG      = 3'h3;
    localparam logic [2:0] HC_CLEAR         = 3'h4;
    localparam logic [2:0] HC_STAT_RD       = 3'h5;
    localparam logic [2:0] HC_CFG_WR        = 3'h6;
    localparam logic [2:0] HC_CFG_RD        = 3'h7;
endpackage

//--- design/otpsp_sync.sv
// otpsp_sync: two-flop synchroniser for one level from another domain
// assumes the input is a plain level; only the second flop is visible
module otpsp_sync (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;
    // first flop feeds only the second
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            q_o      <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

//--- verif/otpsp_asserts.sv
// otpsp_asserts: timing and framing checks on the serial link between host and device ends, plus a hold check on the freeze bit
// assumes plain copies of the link wires, the device config output, clock and reset
module otpsp_asserts (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       miso,
    input  wire logic [7:0] config_reg_one_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    logic       sck_q;
    logic [5:0] rise_cnt;

    // count rising serial clocks per frame; cleared while deselected so a cut frame
    // cannot leak its count into the next one
    always_ff @(posedge clk_sys_i) begin
        sck_q <= sck;
        if (!rst_n_i || cs_n) rise_cnt <= 6'h00;
        else if (sck && !sck_q) rise_cnt <= rise_cnt + 6'h01;
    end

    property p_sck_idle;
        cs_n |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("serial clock moved while deselected");

    property p_cs_lead;
        $fell(cs_n) |-> !sck;
    endproperty
    a_cs_lead: assert property (p_cs_lead)
        else $error("select fell with clock high");

    property p_sck_high;
        $rose(sck) |-> sck [*4] ##1 !sck;
    endproperty
    a_sck_high: assert property (p_sck_high)
        else $error("clock high phase not four cycles");

    property p_sck_low;
        $fell(sck) |-> !sck [*3];
    endproperty
    a_sck_low: assert property (p_sck_low)
        else $error("clock low phase too short");

    property p_mosi_hold;
        (sck && $past(sck)) |-> $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("command data moved in high phase");

    property p_miso_hold;
        (!cs_n && sck && $past(sck)) |-> $stable(miso);
    endproperty
    a_miso_hold: assert property (p_miso_hold)
        else $error("reply data moved in high phase");

    property p_frame_bytes;
        $rose(cs_n) |-> (rise_cnt inside {6'h08, 6'h10, 6'h18, 6'h20});
    endproperty
    a_frame_bytes: assert property (p_frame_bytes)
        else $error("frame not whole bytes");

    // freeze is volatile but only a reset may drop it
    property p_freeze_hold;
        config_reg_one_o[otpsp_pkg::CFG_FREEZE_BIT]
            |=> config_reg_one_o[otpsp_pkg::CFG_FREEZE_BIT];
    endproperty
    a_freeze_hold: assert property (p_freeze_hold)
        else $error("freeze dropped without reset");
endmodule

//--- verif/test_otp_space_protection.sv
// test_otp_space_protection: drives the host end over avalon, checks against a byte model
// assumes both ends joined by one link interface; the host end makes the serial clock
module test_otp_space_protection;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i     = 1'b0;
    logic        rst_n_i       = 1'b0;
    logic [2:0]  avs_address   = 3'h0;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  status_reg_one_o;
    logic [7:0]  config_reg_one_o;
    int          n_errors      = 0;
    int          total_checks  = 0;
    logic [7:0]  mdl [0:1023];
    logic [7:0]  sig [4]       = '{8'h53, 8'h46, 8'h44, 8'h50};
    logic        mdl_perr      = 1'b0;
    logic        mdl_frz       = 1'b0;
    logic [31:0] rd;
    int          r;

    otpsp_link_if link ();
    otpsp_host otpsp_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
    otpsp_device otpsp_device_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link),
        .status_reg_one_o(status_reg_one_o), .config_reg_one_o(config_reg_one_o));
    otpsp_asserts otpsp_asserts_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n(link.cs_n),
        .sck(link.sck), .mosi(link.mosi), .miso(link.miso), .config_reg_one_o(config_reg_one_o));

    always #20 clk_sys_i = ~clk_sys_i;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // one avalon transfer; request held until waitrequest is seen low at an edge
    task automatic bus(input logic [2:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk_sys_i);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    // full serial command: load, start, poll busy, fetch the received byte
    task automatic run_cmd(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d);
        bus(otpsp_pkg::CR_ADDR, 1'b1, {16'h0000, a});
        bus(otpsp_pkg::CR_WDATA, 1'b1, {24'h000000, d});
        bus(otpsp_pkg::CR_CMD, 1'b1, {29'h0, c});
        do bus(otpsp_pkg::CR_STATUS, 1'b0, 32'h0); while (rd[0] !== 1'b0);
        bus(otpsp_pkg::CR_RDATA, 1'b0, 32'h0);
    endtask

    task automatic rd_otp(input logic [15:0] a, input logic [7:0] exp);
        run_cmd(otpsp_pkg::HC_OTP_RD, a, 8'h00);
        check("otp byte", {24'h0, exp}, rd);
    endtask

    task automatic chk_regs;
        run_cmd(otpsp_pkg::HC_STAT_RD, 16'h0000, 8'h00);
        check("status", {25'h0, mdl_perr, 6'h00}, rd);
        check("status port", {25'h0, mdl_perr, 6'h00}, {24'h0, status_reg_one_o});
        run_cmd(otpsp_pkg::HC_CFG_RD, 16'h0000, 8'h00);
        check("config", {31'h0, mdl_frz}, rd);
        check("config port", {31'h0, mdl_frz}, {24'h0, config_reg_one_o});
    endtask

    // model: lock or freeze refuses with error, factory bytes refused silently, else and-in
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        logic [9:0] b;
        logic       lk;
        b  = a[9:0];
        lk = mdl[{8'h04, b[9:8]}][b[7:5]];
        run_cmd(otpsp_pkg::HC_OTP_PROG, a, d);
        if (mdl_frz || !lk) mdl_perr = 1'b1;
        else if (b > otpsp_pkg::RAND_LAST) mdl[b] = mdl[b] & d;
        rd_otp(a, mdl[b]);
        chk_regs();
    endtask

    task automatic clear_err;
        run_cmd(otpsp_pkg::HC_CLEAR, 16'h0000, 8'h00);
        mdl_perr = 1'b0;
        chk_regs();
    endtask

    task automatic do_reset;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        mdl_perr = 1'b0;
        mdl_frz  = 1'b0;
    endtask

    initial begin
        for (int i = 0; i < 1024; i++) mdl[i] = otpsp_pkg::ERASED_BYTE;
        void'($urandom(90));
        do_reset();
        chk_regs();
        bus(3'h6, 1'b1, 32'hFFFFFFFF);
        bus(3'h6, 1'b0, 32'h0);
        check("unmapped read", 32'h0, rd);
        foreach (sig[i]) begin
            run_cmd(otpsp_pkg::HC_PARAM_RD, 16'(i), 8'h00);
            check("param byte", {24'h0, sig[i]}, rd);
        end
        $display("test 1 done: reset values and parameter space");
        // factory values are arbitrary, so they are learnt once and must never change
        for (int i = 0; i < 16; i++) begin
            run_cmd(otpsp_pkg::HC_OTP_RD, 16'(i), 8'h00);
            mdl[i] = rd[7:0];
        end
        prog(16'h0005, 8'h00);
        prog(16'h000F, ~mdl[15]);
        $display("test 2 done: factory bytes");
        rd_otp(16'h0010, 8'hFF);
        rd_otp(16'h0013, 8'hFF);
        prog(16'h0014, 8'hA5);
        prog(16'h001F, 8'h3C);
        rd_otp(16'h03FF, 8'hFF);
        prog(16'hFC20, 8'h5A);
        rd_otp(16'h0020, mdl[10'h020]);
        prog(16'h03FF, 8'h0F);
        prog(16'h03FF, 8'hF0);
        repeat (6) begin
            r = $urandom_range(1023, 32);
            rd_otp(16'(r), mdl[r]);
            prog(16'(r), 8'($urandom));
        end
        $display("test 3 done: erased space and programming");
        prog(16'h0013, 8'h7F);
        prog(16'h03E4, 8'h00);
        clear_err();
        r = $urandom_range(29, 1);
        prog(16'h0010 + 16'(r / 8), ~(8'h01 << (r % 8)));
        prog(16'(r * 32 + 3), 8'h00);
        clear_err();
        prog(16'((r + 1) * 32 + 7), 8'h81);
        $display("test 4 done: region locks");
        run_cmd(otpsp_pkg::HC_CFG_WR, 16'h0000, 8'h01);
        mdl_frz = 1'b1;
        chk_regs();
        prog(16'h0040, 8'h00);
        prog(16'h0005, 8'h00);
        clear_err();
        // a mid-run reset clears volatile state but must keep every programmed byte
        do_reset();
        chk_regs();
        rd_otp(16'h0013, mdl[10'h013]);
        rd_otp(16'h0014, mdl[10'h014]);
        prog(16'h03E0, 8'h00);
        clear_err();
        prog(16'h0040, 8'h00);
        $display("test 5 done: freeze and reset");
        print_verdict();
    end

    // watchdog: the whole sequence needs well under this many cycles
    initial begin
        repeat (95000) @(posedge clk_sys_i);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        print_verdict();
    end
endmodule
